// file: mtcl_defs.vh
// Notes on behaviour
// R1 - lane widths 1,2,4,8; up to eight targets
// R2 - integrator picks smallest covering lane width
// R3 - unassigned lanes carry idle, no image
// R4 - shared lane carries images back to back
// R5 - broadcast targets start and finish together
// R6 - master generates shift clock for everyone
// R7 - first source select follows load-complete
// R8 - data sent: drive cascade select low
// R9 - cascade hand-off within one clock period
// R10 - no load-complete rise: drop chain enable
// R11 - low chain enable resets every target
// R12 - any error halts and reloads whole chain
// R13 - jtag reload instruction pulses reload request
// R14 - only first source drives reconfiguration input
// R15 - load-complete and status lines joined chain-wide
// R16 - user mode 299 init clocks after load-complete
// R17 - init clock internal or user start-up clock
// R18 - wait 64 or 16 shift clocks for done
// R19 - restart once status high after reset timeout
// R20 - one bit per active lane per edge
`ifndef MTCL_DEFS_VH
`define MTCL_DEFS_VH
`define MTCL_WAIT_ENH      8'd64
`define MTCL_WAIT_SIMPLE   8'd16
`define MTCL_INIT_CYCLES   9'd299
`define MTCL_CLK_NS        50
`define MTCL_TIMEOUT_NS    40000
`define MTCL_RELOAD_CYC    8'd40
`define MTCL_LANE_MAX      4'd8
`define MTCL_SHIFT_DIV     4'd4
`endif

// file: mtcl_fifo.v
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// word fifo between image store and shifter
// ----------------------------------------
module mtcl_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             mclk,
    input  wire             reset,
    input  wire             flush,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];   // storage
    reg [AW-1:0]    wr_ptr;            // write index
    reg [AW-1:0]    rd_ptr;            // read index
    reg [AW:0]      count;             // fill level
    reg             room;              // not full, kept in a flop
    wire            push;
    wire            pop;
    assign in_ready  = room;
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    // pointers and level; flush empties in one cycle
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            room   <= 1'b1;
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else if (flush) begin
            room   <= 1'b1;
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            if (pop) room <= 1'b1;
            else if (push && count == DEPTH[AW:0] - 1'b1) room <= 1'b0;
            if (push & ~pop) count <= count + 1'b1;
            else if (pop & ~push) count <= count - 1'b1;
        end
    end
    // memory has no reset, data only
    always @(posedge mclk) begin
        if (push) mem[wr_ptr] <= in_data;
    end
endmodule // mtcl_fifo
`default_nettype wire

// file: mtcl_loader.v
`timescale 1ns/100ps
`default_nettype none
`include "mtcl_defs.vh"
// ----------------------------------------
// serial configuration source, one of a cascade
// ----------------------------------------
module mtcl_loader #(
    parameter LANES    = 8,           // active lanes: 1, 2, 4 or 8
    parameter MAX_LEN  = 32,          // words in the longest lane
    parameter ENHANCED = 1            // 1: 64 clock wait, 0: 16
) (
    input  wire             mclk,
    input  wire             reset,
    input  wire             is_master,           // drives shift clock
    input  wire             user_clock_select,   // init clock from user pin
    input  wire             user_startup_clock,  // asynchronous pin
    input  wire             ext_shift_clock,     // shift clock from master
    input  wire             source_select_low,   // asynchronous pin
    input  wire             chain_enable_in,     // asynchronous pin
    input  wire             load_done_in,        // shared load-complete
    input  wire             status_in,           // shared status line
    input  wire             jtag_reload,         // one-cycle instruction strobe
    input  wire [7:0]       lane_mask,           // populated lanes
    input  wire [LANES*8-1:0] lane_len,          // words per lane
    input  wire [7:0]       word_data,           // image words, lane-interleaved
    input  wire             word_valid,
    output wire             word_ready,
    output reg              serial_shift_clock,
    output reg  [7:0]       serial_lanes,        // bit 0 is serial_lane_zero
    output reg              cascade_select_out,
    output reg              chain_enable_out,
    output reg              reload_request_low,
    output reg              user_mode,
    output reg              load_error
);
    localparam ST_IDLE = 3'd0;
    localparam ST_SEND = 3'd1;
    localparam ST_WAIT = 3'd2;
    localparam ST_INIT = 3'd3;
    localparam ST_FAIL = 3'd4;
    localparam ST_DONE = 3'd5;

    // ----------------------------------------
    // three-stage synchronisers for pins
    // ----------------------------------------
    reg [2:0] sy_sel;   // source select
    reg [2:0] sy_done;  // load complete
    reg [2:0] sy_stat;  // status
    reg [2:0] sy_ce;    // chain enable in
    reg [2:0] sy_uclk;  // user start-up clock
    reg [2:0] sy_sclk;  // external shift clock
    reg       sel_q, done_q, stat_q, ce_q, uclk_q, sclk_q;  // agreed levels
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            sy_sel <= 3'h7; sy_done <= 3'h0; sy_stat <= 3'h0;
            sy_ce <= 3'h7; sy_uclk <= 3'h0; sy_sclk <= 3'h0;
            sel_q <= 1'b1; done_q <= 1'b0; stat_q <= 1'b0;
            ce_q <= 1'b1; uclk_q <= 1'b0; sclk_q <= 1'b0;
        end else begin
            sy_sel  <= {sy_sel[1:0], source_select_low};
            sy_done <= {sy_done[1:0], load_done_in};
            sy_stat <= {sy_stat[1:0], status_in};
            sy_ce   <= {sy_ce[1:0], chain_enable_in};
            sy_uclk <= {sy_uclk[1:0], user_startup_clock};
            sy_sclk <= {sy_sclk[1:0], ext_shift_clock};
            if (sy_sel[2] == sy_sel[1]) sel_q <= sy_sel[2];
            if (sy_done[2] == sy_done[1]) done_q <= sy_done[2];
            if (sy_stat[2] == sy_stat[1]) stat_q <= sy_stat[2];
            if (sy_ce[2] == sy_ce[1]) ce_q <= sy_ce[2];
            if (sy_uclk[2] == sy_uclk[1]) uclk_q <= sy_uclk[2];
            if (sy_sclk[2] == sy_sclk[1]) sclk_q <= sy_sclk[2];
        end
    end

    // ----------------------------------------
    // image buffer in the data path
    // ----------------------------------------
    wire [7:0] fifo_data;
    wire       fifo_valid;
    reg        fifo_take;
    reg        fifo_flush;
    mtcl_fifo #(.WIDTH(8), .DEPTH(32), .AW(5)) i_mtcl_fifo (
        .mclk      (mclk),
        .reset     (reset),
        .flush     (fifo_flush),
        .in_data   (word_data),
        .in_valid  (word_valid),
        .in_ready  (word_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_take)
    );

    // ----------------------------------------
    // shift tick: own divider or edge of master clock
    // ----------------------------------------
    reg [3:0] div_cnt;     // divider for own shift clock
    reg       sclk_prev;   // previous agreed master clock level
    reg       uclk_prev;   // previous agreed user clock level
    reg       int_osc;     // internal init clock stand-in
    wire      own_fall = is_master & (div_cnt == `MTCL_SHIFT_DIV - 4'd1) & serial_shift_clock;
    wire      ext_fall = ~is_master & sclk_prev & ~sclk_q;
    wire      shift_tick = own_fall | ext_fall;        // data changes on falling edge
    wire      init_tick = user_clock_select ? (uclk_q & ~uclk_prev) : int_osc;  // R17
    reg [2:0] state;
    wire      running = (state == ST_SEND) | (state == ST_WAIT);
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            div_cnt <= 4'h0; serial_shift_clock <= 1'b0;
            sclk_prev <= 1'b0; uclk_prev <= 1'b0; int_osc <= 1'b0;
        end else begin
            sclk_prev <= sclk_q;
            uclk_prev <= uclk_q;
            int_osc   <= ~int_osc;
            // master drives the one shift clock of the chain
            if (is_master & running) begin // R6
                if (div_cnt == `MTCL_SHIFT_DIV - 4'd1) begin
                    div_cnt <= 4'h0;
                    serial_shift_clock <= ~serial_shift_clock;
                end else begin
                    div_cnt <= div_cnt + 4'h1;
                end
            end else begin
                div_cnt <= 4'h0;
                serial_shift_clock <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // lane sequencer and chain control
    // ----------------------------------------
    reg [7:0]  lane_idx;    // lane whose word is next from the fifo
    reg [7:0]  word_idx;    // word position within every lane
    reg [2:0]  bit_idx;     // bit within the current words
    reg [63:0] shreg;       // current word per lane
    reg [7:0]  wait_cnt;    // shift clocks waited for done
    reg [8:0]  init_cnt;    // init clocks after done
    reg [7:0]  rst_cnt;     // reset timeout counter
    reg        filling;     // loading one word per lane
    wire [7:0] wait_max = ENHANCED ? `MTCL_WAIT_ENH : `MTCL_WAIT_SIMPLE;  // R18
    wire [7:0] max_len;
    wire [7:0] next_lanes;
    wire       enabled = ~sel_q & ce_q & stat_q;      // R7 R11

    // longest lane decides the end of the stream
    genvar g;
    wire [7:0] len_run [0:LANES];
    assign len_run[0] = 8'h00;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_len
            assign len_run[g+1] = (lane_mask[g] && lane_len[g*8 +: 8] > len_run[g])
                                  ? lane_len[g*8 +: 8] : len_run[g];
        end
    endgenerate
    assign max_len = len_run[LANES];

    // drained only while refilling; preloaded words survive idle
    always @* begin
        fifo_take  = (state == ST_SEND) & filling & fifo_valid;
        fifo_flush = (state == ST_FAIL) | jtag_reload | (running & ~(ce_q & stat_q));
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE; lane_idx <= 8'h0; word_idx <= 8'h0; bit_idx <= 3'h0;
            shreg <= 64'h0; wait_cnt <= 8'h0; init_cnt <= 9'h0; rst_cnt <= 8'h0;
            filling <= 1'b1; serial_lanes <= 8'h00; cascade_select_out <= 1'b1;
            chain_enable_out <= 1'b1; reload_request_low <= 1'b1;
            user_mode <= 1'b0; load_error <= 1'b0;
        end else begin
            reload_request_low <= ~jtag_reload;            // R13
            if (jtag_reload) begin
                state <= ST_IDLE;                         // R12
                cascade_select_out <= 1'b1;
                user_mode <= 1'b0;
            end else if ((!ce_q || !stat_q) && state != ST_FAIL) begin
                // chain held in reset: send and wait stop and restart after release; fail keeps timing
                if (running) state <= ST_IDLE;            // R11 R12
                serial_lanes <= 8'h00;
                cascade_select_out <= 1'b1;
                user_mode <= 1'b0;
            end else begin
                case (state)
                ST_IDLE: begin
                    // restart once status is high again
                    chain_enable_out <= 1'b1;             // R19
                    word_idx <= 8'h0; lane_idx <= 8'h0; filling <= 1'b1;
                    bit_idx <= 3'h0; wait_cnt <= 8'h0; init_cnt <= 9'h0;
                    if (enabled && max_len != 8'h00) state <= ST_SEND;
                end
                ST_SEND: begin
                    if (filling) begin
                        // gather one word per lane, in lane order
                        if (fifo_valid) begin
                            shreg[lane_idx[2:0]*8 +: 8] <= fifo_data;  // R4
                            if (lane_idx == LANES - 1) begin
                                lane_idx <= 8'h0;
                                filling <= 1'b0;
                            end else begin
                                lane_idx <= lane_idx + 8'h1;
                            end
                        end
                    end else if (shift_tick) begin
                        serial_lanes <= next_lanes;        // R20
                        bit_idx <= bit_idx + 3'h1;
                        if (bit_idx == 3'h7) begin
                            filling <= 1'b1;
                            word_idx <= word_idx + 8'h1;
                            if (word_idx + 8'h1 == max_len) begin
                                // hand-off in the same tick keeps the stream whole
                                cascade_select_out <= 1'b0; // R8 R9
                                state <= ST_WAIT;
                            end
                        end
                    end
                end
                ST_WAIT: begin
                    // count shift clocks until load-complete rises
                    if (done_q) begin                     // R15
                        state <= ST_INIT;
                    end else if (shift_tick) begin
                        if (wait_cnt == wait_max - 8'h1) begin
                            state <= ST_FAIL;             // R10
                        end else begin
                            wait_cnt <= wait_cnt + 8'h1;  // R18
                        end
                    end
                end
                ST_INIT: begin
                    serial_lanes <= 8'h00;
                    if (init_tick) begin
                        if (init_cnt == `MTCL_INIT_CYCLES - 9'd1) begin
                            state <= ST_DONE;             // R16
                            user_mode <= 1'b1;
                        end else begin
                            init_cnt <= init_cnt + 9'd1;
                        end
                    end
                end
                ST_FAIL: begin
                    // master pulls chain enable low for the reset timeout; a non-master source drives it high
                    load_error <= 1'b1;
                    chain_enable_out <= ~is_master;       // R10 R11
                    if (rst_cnt == `MTCL_RELOAD_CYC) begin
                        rst_cnt <= 8'h0;
                        chain_enable_out <= 1'b1;
                        state <= ST_IDLE;                 // R19
                    end else begin
                        rst_cnt <= rst_cnt + 8'h1;
                    end
                end
                ST_DONE: begin
                    load_error <= 1'b0;
                    if (!done_q) state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // per-lane bit select; empty or ended lanes idle low
    // ----------------------------------------
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_lane
            if (g < LANES) begin : g_on
                assign next_lanes[g] = lane_mask[g] && (word_idx < lane_len[g*8 +: 8])
                                       ? shreg[g*8 + 7 - bit_idx] : 1'b0;  // R3 R5
            end else begin : g_off
                assign next_lanes[g] = 1'b0;                // R1
            end
        end
    endgenerate
endmodule // mtcl_loader
`default_nettype wire

// file: mtcl_loader_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// port checker for the configuration source
// ----------------------------------------
module mtcl_loader_asserts (
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic       jtag_reload,
    input wire logic       user_clock_select,
    input wire logic       load_done_in,
    input wire logic       status_in,
    input wire logic [7:0] lane_mask,
    input wire logic       serial_shift_clock,
    input wire logic [7:0] serial_lanes,
    input wire logic       cascade_select_out,
    input wire logic       chain_enable_out,
    input wire logic       reload_request_low,
    input wire logic       user_mode,
    input wire logic       load_error
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic [11:0] done_cnt;  // cycles with load-complete high, saturating
    // counts how long load-complete has stood, for the start-up count
    always @(posedge mclk or posedge reset) begin
        if (reset) done_cnt <= 12'h000;
        else if (!load_done_in) done_cnt <= 12'h000;
        else if (done_cnt != 12'hfff) done_cnt <= done_cnt + 12'h001;
    end
    chk_unused_lanes: assert property ((serial_lanes & ~lane_mask) == 8'h00)
        else $error("unpopulated lane carries data");
    // data moves only in the low phase, so targets see it settled at the rise
    chk_lane_timing: assert property ($changed(serial_lanes) && status_in && chain_enable_out
        && !load_error |-> !serial_shift_clock)
        else $error("lane data changed outside the low phase");
    chk_low_phase: assert property ($fell(serial_shift_clock) |-> (!serial_shift_clock) [*4])
        else $error("shift clock low phase too short");
    chk_high_phase: assert property ($fell(serial_shift_clock) && status_in && !load_done_in
        |-> $past(serial_shift_clock, 4))
        else $error("shift clock high phase too short");
    chk_clock_init: assert property (user_mode |-> !serial_shift_clock)
        else $error("shift clock runs in user mode");
    chk_reload_pulse: assert property (1'b1 |=> reload_request_low == !$past(jtag_reload))
        else $error("reload request does not follow the instruction");
    chk_init_count: assert property ($rose(user_mode) |-> (user_clock_select ?
        (done_cnt inside {[12'd2380:12'd2412]}) : (done_cnt inside {[12'd594:12'd612]})))
        else $error("user mode entered after wrong start-up count");
    chk_error_cause: assert property ($rose(load_error) |-> !load_done_in)
        else $error("error raised although load completed");
    chk_enable_error: assert property ($fell(chain_enable_out) |-> ##[0:1] load_error)
        else $error("chain enable dropped without error");
    chk_enable_hold: assert property ($fell(chain_enable_out) |=> (!chain_enable_out) [*8])
        else $error("chain reset too short");
    chk_cascade_hold: assert property ($fell(cascade_select_out)
        |-> !user_mode ##1 (!cascade_select_out) [*8])
        else $error("cascade select did not hold low");
    cov_user_mode: cover property ($rose(user_mode));
    cov_error: cover property ($rose(load_error));
    cov_cascade: cover property ($fell(cascade_select_out));
    cov_reload: cover property ($fell(reload_request_low));
endmodule // mtcl_loader_asserts
bind mtcl_loader mtcl_loader_asserts i_mtcl_loader_asserts (
    .mclk(mclk), .reset(reset), .jtag_reload(jtag_reload),
    .user_clock_select(user_clock_select), .load_done_in(load_done_in),
    .status_in(status_in), .lane_mask(lane_mask), .serial_shift_clock(serial_shift_clock),
    .serial_lanes(serial_lanes), .cascade_select_out(cascade_select_out),
    .chain_enable_out(chain_enable_out), .reload_request_low(reload_request_low),
    .user_mode(user_mode), .load_error(load_error));
`default_nettype wire

// file: mtcl_target_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// target chain on the far side of the lanes
// ----------------------------------------
module mtcl_target_model #(
    parameter int NBITS = 16                 // image bits per lane
) (
    input  wire logic        mclk,
    input  wire logic        clear,          // power-on of the targets
    input  wire logic        shift_clock,
    input  wire logic [7:0]  lanes,
    input  wire logic        chain_enable,   // low holds status low; released 40 cycles after it rises
    input  wire logic        fail_mode,      // never report load complete
    output logic             load_done,
    output logic             status,
    output logic [NBITS-1:0] got0,           // lane 0 bits, first at msb
    output logic [NBITS-1:0] got1
);
    int   n_bits;     // rising edges with valid data
    int   hold;       // reset timeout left
    logic seen_fall;  // data is defined only after the first falling edge
    // a rise before any fall would sample idle lanes
    always @(negedge shift_clock or posedge clear) begin
        if (clear) seen_fall <= 1'b0;
        else seen_fall <= 1'b1;
    end
    // every target takes one bit of lane 0 and lane 1 on the rising edge
    always @(posedge shift_clock or posedge clear) begin
        if (clear) begin
            n_bits    <= 0;
            load_done <= 1'b0;
        end else if (seen_fall) begin
            if (n_bits < NBITS) begin
                got0 <= {got0[NBITS-2:0], lanes[0]};
                got1 <= {got1[NBITS-2:0], lanes[1]};
            end
            n_bits <= n_bits + 1;
            // joined load-complete line: all targets finish together
            if (n_bits == NBITS + 2 && !fail_mode) load_done <= 1'b1;
        end
    end
    // joined status line: low in chain reset, released after a timeout
    always @(posedge mclk or posedge clear) begin
        if (clear) begin
            status <= 1'b1;
            hold   <= 0;
        end else if (!chain_enable) begin
            status <= 1'b0;
            hold   <= 40;
        end else if (hold > 0) hold <= hold - 1;
        else status <= 1'b1;
    end
endmodule // mtcl_target_model
`default_nettype wire

// file: multi_target_serial_config_loader_bench.sv
`timescale 1ns/100ps
`default_nettype none
module multi_target_serial_config_loader_bench;
    // ----------------------------------------
    // stimulus and wiring
    // ----------------------------------------
    typedef struct {
        logic [7:0] mask;  // populated lanes
        logic [7:0] len0;  // words in lane 0
        logic [7:0] len1;  // words in lane 1
        logic       fail;  // targets never report load complete
        logic       uclk;  // start-up count on the user clock
    } mtcl_row_t;
    logic        mclk = 1'b0;
    logic        reset = 1'b0;
    logic        uclk_sel = 1'b0;
    logic        user_clk = 1'b0;
    logic        ext_clk = 1'b0;
    logic        ext_run = 1'b0;   // link clock stands still outside frames
    logic        hold_off = 1'b1;  // keeps the source deselected while filling
    logic        jtag = 1'b0;
    logic        fail_mode = 1'b0;
    logic [7:0]  mask = 8'h00;
    logic [15:0] lens = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wvalid = 1'b0;
    wire         wready, sclk, casc, cen, rld_n, umode, lerr, done, stat;
    wire  [7:0]  lanes;
    wire  [15:0] got0, got1;
    int          fail_count = 0;
    int          n_compared = 0;
    mtcl_row_t   rows [5] = '{'{8'h03, 8'd2, 8'd2, 1'b0, 1'b0}, '{8'h01, 8'd2, 8'd0, 1'b0, 1'b0},
        '{8'h03, 8'd2, 8'd1, 1'b0, 1'b0}, '{8'h03, 8'd2, 8'd2, 1'b1, 1'b0},
        '{8'h02, 8'd0, 8'd2, 1'b0, 1'b1}};
    // first source is selected while load-complete is low
    mtcl_loader #(.LANES(2), .MAX_LEN(2), .ENHANCED(1)) i_mtcl_loader (
        .mclk(mclk), .reset(reset), .is_master(1'b1), .user_clock_select(uclk_sel),
        .user_startup_clock(user_clk), .ext_shift_clock(ext_clk),
        .source_select_low(done | hold_off), .chain_enable_in(cen), .load_done_in(done),
        .status_in(stat), .jtag_reload(jtag), .lane_mask(mask), .lane_len(lens),
        .word_data(wdata), .word_valid(wvalid), .word_ready(wready),
        .serial_shift_clock(sclk), .serial_lanes(lanes), .cascade_select_out(casc),
        .chain_enable_out(cen), .reload_request_low(rld_n), .user_mode(umode),
        .load_error(lerr));
    mtcl_target_model #(.NBITS(16)) i_mtcl_target_model (
        .mclk(mclk), .clear(reset), .shift_clock(sclk), .lanes(lanes), .chain_enable(cen),
        .fail_mode(fail_mode), .load_done(done), .status(stat), .got0(got0), .got1(got1));
    initial forever #25 mclk = ~mclk;
    // 400 ns clocks, phase unrelated to mclk
    initial begin
        #7;
        forever begin
            #200;
            user_clk = ~user_clk;
            if (ext_run) ext_clk = ~ext_clk;
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d, mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    function automatic logic [7:0] pat(input int k, input int j);
        pat = 8'hc3 ^ 8'(16 * j + k);
    endfunction
    // ended or unpopulated lanes shift zeros, word 0 first, msb first
    function automatic logic [15:0] exp_lane(input int j, input mtcl_row_t r);
        logic [7:0] len;
        len = (j == 0) ? r.len0 : r.len1;
        exp_lane = 16'h0000;
        if (r.mask[j] && len > 8'd0) exp_lane[15:8] = pat(0, j);
        if (r.mask[j] && len > 8'd1) exp_lane[7:0] = pat(1, j);
    endfunction
    task automatic do_reset();
        reset <= 1'b1;
        @(posedge mclk);
        #1 cmp_word({2'b00, sclk, lanes, casc, cen, rld_n, umode, lerr}, 16'h001c);
        @(posedge mclk);
        reset <= 1'b0;
    endtask
    // valid and data stand until an edge samples ready high
    task automatic push(input logic [7:0] w);
        int t;
        wdata  <= w;
        wvalid <= 1'b1;
        @(posedge mclk);
        for (t = 0; t < 100 && wready !== 1'b1; t++) @(posedge mclk);
    endtask
    task automatic run_row(input mtcl_row_t r);
        int i;
        int t;
        fail_mode <= r.fail;
        mask      <= r.mask;
        lens      <= {r.len1, r.len0};
        uclk_sel  <= r.uclk;
        hold_off  <= 1'b1;
        ext_run   <= 1'b0;
        do_reset();
        for (i = 0; i < 4; i++) push(pat(i / 2, i % 2));
        wvalid   <= 1'b0;
        hold_off <= 1'b0;
        ext_run  <= 1'b1;
        for (t = 0; t < 4000 && umode !== 1'b1 && lerr !== 1'b1; t++) @(posedge mclk);
        cmp_bit(umode, !r.fail);
        cmp_bit(lerr, r.fail);
        cmp_word(got0, exp_lane(0, r));
        cmp_word(got1, exp_lane(1, r));
        if (!r.fail) cmp_bit(casc, 1'b0);
        else begin
            repeat (4) @(posedge mclk);
            #1 cmp_bit(cen, 1'b0);
            repeat (6) @(posedge mclk);
            #1 cmp_bit(stat, 1'b0);
            @(posedge mclk);
        end
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        int i;
        int n;
        for (i = 0; i < 5; i++) run_row(rows[i]);
        // reload instruction after a good load
        jtag <= 1'b1;
        @(posedge mclk);
        jtag <= 1'b0;
        #1 cmp_bit(rld_n, 1'b0);
        @(posedge mclk);
        #1 cmp_bit(rld_n, 1'b1);
        repeat (4) @(posedge mclk);
        #1 cmp_bit(umode, 1'b0);
        // mid-run reset, then fill the word buffer until it refuses
        @(posedge mclk);
        hold_off <= 1'b1;
        do_reset();
        wvalid <= 1'b1;
        n = 0;
        repeat (40) begin
            @(posedge mclk);
            if (wready === 1'b1) n++;
        end
        wvalid <= 1'b0;
        cmp_word(16'(n), 16'd32);
        stop_test();
    end
    // whole run is under 10000 cycles; allow twice that
    initial begin
        #1000000;
        fail_count++;
        stop_test();
    end
endmodule // multi_target_serial_config_loader_bench
`default_nettype wire
